/* File: logic/boostc_pkg.sv */
// Package of register map, field layout and timing constants for the boost control block
package boostc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // Register index; the byte address on the bus is four times this
    localparam logic [7:0] CTRL_INDEX = 8'h66;
    localparam int ADR_W = 10;

    // ------------------------------------------------------------
    // Field layout of boost_control
    // ------------------------------------------------------------
    localparam int VOLT_LSB = 0;
    localparam int RUN_MODE_LSB = 2;
    localparam int STBY_MODE_LSB = 5;
    localparam int RSVD4_BIT = 4;
    localparam int RSVD7_BIT = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] VOLT_RST = 2'h0;
    localparam logic [1:0] RUN_MODE_RST = 2'h2;
    localparam logic [1:0] STBY_MODE_RST = 2'h2;

    // ------------------------------------------------------------
    // Switching mode encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PFM = 2'h1;
    localparam logic [1:0] MODE_AUTO = 2'h2;
    localparam logic [1:0] MODE_HEAVY = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Load level must hold this many cycles before auto mode follows it
    localparam int AUTO_DWELL_CYC = 4;
    localparam int DWELL_W = 3;

endpackage

/* File: logic/boostc_auto_sel.sv */
// Switching mode resolver with automatic light/heavy load selection
`timescale 1ns/10ps

module boostc_auto_sel (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    input wire logic heavy_sync_i,
    output logic enable_o,
    output logic pfm_o,
    output logic heavy_o
);

    // ------------------------------------------------------------
    // Auto mode load tracking
    // ------------------------------------------------------------
    localparam int DWELL_W = boostc_pkg::DWELL_W;
    logic auto_heavy_q;
    logic auto_heavy_d;
    logic [boostc_pkg::DWELL_W-1:0] dwell_q;
    logic [boostc_pkg::DWELL_W-1:0] dwell_d;
    logic en_q;
    logic en_d;
    logic pfm_q;
    logic pfm_d;
    logic heavy_q;
    logic heavy_d;
    logic is_auto;

    assign is_auto = (mode_i == boostc_pkg::MODE_AUTO);

    // Dwell filter keeps the converter from chattering near the threshold
    // auto mode tracks load
    always_comb begin
        auto_heavy_d = auto_heavy_q;
        dwell_d = '0;
        if (heavy_sync_i != auto_heavy_q) begin
            if (dwell_q == DWELL_W'(boostc_pkg::AUTO_DWELL_CYC - 1)) begin
                auto_heavy_d = heavy_sync_i;
            end else begin
                dwell_d = dwell_q + DWELL_W'(1);
            end
        end
    end

    // Output decode of the effective mode
    always_comb begin
        en_d = (mode_i != boostc_pkg::MODE_OFF);
        pfm_d = (mode_i == boostc_pkg::MODE_PFM) || (is_auto && !auto_heavy_q);
        heavy_d = (mode_i == boostc_pkg::MODE_HEAVY) || (is_auto && auto_heavy_q);
    end

    // Auto starts light, so a fresh start comes up in pulse-frequency mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_heavy_q <= 1'b0;
            dwell_q <= '0;
            en_q <= 1'b0;
            pfm_q <= 1'b0;
            heavy_q <= 1'b0;
        end else begin
            auto_heavy_q <= auto_heavy_d;
            dwell_q <= dwell_d;
            en_q <= en_d;
            pfm_q <= pfm_d;
            heavy_q <= heavy_d;
        end
    end

    assign enable_o = en_q;
    assign pfm_o = pfm_q;
    assign heavy_o = heavy_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // heavy load reaches output
    chk_auto_goes_heavy: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (is_auto && heavy_sync_i) [*6] |=> (heavy_o && !pfm_o))
        else $error("auto mode did not follow heavy load");

    chk_auto_goes_light: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (is_auto && !heavy_sync_i) [*6] |=> (pfm_o && !heavy_o))
        else $error("auto mode did not follow light load");

endmodule // boostc_auto_sel

/* File: logic/boostc_ctrl.sv */
// Boost regulator control register and mode selection behind a Wishbone slave
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps

module boostc_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [boostc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic standby_i,
    input wire logic heavy_load_i,
    input wire logic [4:0] boost_sequence_slot_i,
    output logic [1:0] boost_voltage_select_o,
    output logic boost_enable_o,
    output logic boost_pfm_o,
    output logic boost_heavy_o,
    output logic boost_in_sequence_o,
    output logic [1:0] boost_start_mode_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] stby_meta_q;
    logic [1:0] stby_meta_d;
    logic [1:0] heavy_meta_q;
    logic [1:0] heavy_meta_d;
    logic stby_sync;
    logic heavy_sync;

    // Both pins are asynchronous; only the second stage is read
    always_comb begin
        stby_meta_d = {stby_meta_q[0], standby_i};
        heavy_meta_d = {heavy_meta_q[0], heavy_load_i};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stby_meta_q <= 2'h0;
            heavy_meta_q <= 2'h0;
        end else begin
            stby_meta_q <= stby_meta_d;
            heavy_meta_q <= heavy_meta_d;
        end
    end

    assign stby_sync = stby_meta_q[1];
    assign heavy_sync = heavy_meta_q[1];

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    logic req;
    logic adr_hit;
    logic wr_hit;
    logic ack_q;
    logic ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [7:0] ctrl_view;

    assign req = wb_cyc_i && wb_stb_i;
    // Word index sits above the two byte-address bits
    // single register decode
    assign adr_hit = (wb_adr_i[boostc_pkg::ADR_W-1:2] == boostc_pkg::CTRL_INDEX)
        && (wb_adr_i[1:0] == 2'h0);
    // Write lands on the edge where the master sees ack
    assign wr_hit = req && ack_q && wb_we_i && adr_hit && wb_sel_i[0];

    // Answer one cycle after the request, unmapped reads return zero
    always_comb begin
        ack_d = req && !ack_q;
        rdat_d = rdat_q;
        if (req && !ack_q) begin
            rdat_d = adr_hit ? {24'h000000, ctrl_view} : 32'h00000000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ------------------------------------------------------------
    // boost_control register
    // ------------------------------------------------------------
    logic [1:0] volt_q;
    logic [1:0] volt_d;
    logic [1:0] run_mode_q;
    logic [1:0] run_mode_d;
    logic [1:0] stby_mode_q;
    logic [1:0] stby_mode_d;

    // run mode holds its reset value
    always_comb begin
        volt_d = volt_q;
        run_mode_d = run_mode_q;
        stby_mode_d = stby_mode_q;
        if (wr_hit) begin
            volt_d = wb_dat_i[boostc_pkg::VOLT_LSB +: 2];
            stby_mode_d = wb_dat_i[boostc_pkg::STBY_MODE_LSB +: 2];
        end
    end

    // both mode fields reset to auto
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            volt_q <= boostc_pkg::VOLT_RST;
            run_mode_q <= boostc_pkg::RUN_MODE_RST;
            stby_mode_q <= boostc_pkg::STBY_MODE_RST;
        end else begin
            volt_q <= volt_d;
            run_mode_q <= run_mode_d;
            stby_mode_q <= stby_mode_d;
        end
    end

    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[boostc_pkg::VOLT_LSB +: 2] = volt_q;
        ctrl_view[boostc_pkg::RUN_MODE_LSB +: 2] = run_mode_q;
        ctrl_view[boostc_pkg::STBY_MODE_LSB +: 2] = stby_mode_q;
    end

    // ------------------------------------------------------------
    // Sequence membership
    // ------------------------------------------------------------
    logic seq_q;
    logic seq_d;
    logic [1:0] start_mode_q;
    logic [1:0] start_mode_d;

    // Slot bits come from fuse latches on this clock, no synchroniser needed
    // nonzero slot joins sequence
    always_comb begin
        seq_d = (boost_sequence_slot_i != 5'h00);
        start_mode_d = seq_d ? boostc_pkg::MODE_AUTO : boostc_pkg::MODE_OFF;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_q <= 1'b0;
            start_mode_q <= boostc_pkg::MODE_OFF;
        end else begin
            seq_q <= seq_d;
            start_mode_q <= start_mode_d;
        end
    end

    assign boost_in_sequence_o = seq_q;
    assign boost_start_mode_o = start_mode_q;
    assign boost_voltage_select_o = volt_q;

    // ------------------------------------------------------------
    // Effective switching mode
    // ------------------------------------------------------------
    logic [1:0] mode_eff;

    assign mode_eff = stby_sync ? stby_mode_q : run_mode_q;

    boostc_auto_sel boostc_auto_sel_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(mode_eff),
        .heavy_sync_i(heavy_sync),
        .enable_o(boost_enable_o),
        .pfm_o(boost_pfm_o),
        .heavy_o(boost_heavy_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // fields change only by register write
    chk_only_reg_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ($changed(volt_q) || $changed(stby_mode_q)) |-> $past(wr_hit))
        else $error("boost field changed without a register write");

    chk_volt_written: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_hit |=> (boost_voltage_select_o == $past(wb_dat_i[1:0])))
        else $error("voltage select did not take the written value");

    chk_run_mode_fixed: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_hit |=> (run_mode_q == boostc_pkg::MODE_AUTO))
        else $error("read-only run mode was altered");

    chk_stby_written: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_hit |=> (stby_mode_q == $past(wb_dat_i[boostc_pkg::STBY_MODE_LSB +: 2])))
        else $error("standby mode did not take the written value");

    chk_seq_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ##1 (boost_in_sequence_o == ($past(boost_sequence_slot_i) != 5'h00)))
        else $error("sequence membership does not match the slot");

    chk_start_auto: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (run_mode_q == boostc_pkg::MODE_AUTO)
            && (stby_mode_q == boostc_pkg::MODE_AUTO))
        else $error("mode fields did not start in auto");

    chk_stby_select: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (stby_sync && stby_mode_q == boostc_pkg::MODE_OFF) |=> !boost_enable_o)
        else $error("standby off mode left the boost enabled");

    chk_reserved_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && !wb_we_i) |-> !wb_dat_o[boostc_pkg::RSVD7_BIT]
            && !wb_dat_o[boostc_pkg::RSVD4_BIT])
        else $error("reserved bit read as one");

    // Bus answer is a single-cycle pulse one cycle after the request
    chk_ack_timing: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && !ack_q) |=> (wb_ack_o ##1 !wb_ack_o))
        else $error("ack not a one-cycle pulse after request");

    chk_lane_refused: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && ack_q && wb_we_i && adr_hit && !wb_sel_i[0])
            |=> ($stable(volt_q) && $stable(stby_mode_q)))
        else $error("write without lane zero altered a field");

    chk_unmapped_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && !wb_we_i && !adr_hit) |-> (wb_dat_o == 32'h00000000))
        else $error("unmapped read returned nonzero data");

    // read data is the register view
    chk_read_view: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && !wb_we_i && adr_hit) |-> (wb_dat_o == {24'h000000, $past(ctrl_view)}))
        else $error("read data does not match the register");

    chk_stby_heavy: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (stby_sync && stby_mode_q == boostc_pkg::MODE_HEAVY) |=> (boost_heavy_o && !boost_pfm_o))
        else $error("standby heavy mode not applied");

    chk_stby_pfm: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (stby_sync && stby_mode_q == boostc_pkg::MODE_PFM) |=> (boost_pfm_o && !boost_heavy_o))
        else $error("standby pulse-frequency mode not applied");

    chk_start_mode: assert property (
        @(posedge clk_i) disable iff (rst_i)
        boost_start_mode_o
            == (boost_in_sequence_o ? boostc_pkg::MODE_AUTO : boostc_pkg::MODE_OFF))
        else $error("start mode does not match sequence membership");

    // enabled boost is in exactly one switching style
    chk_one_style: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ((boost_pfm_o || boost_heavy_o) == boost_enable_o) && !(boost_pfm_o && boost_heavy_o))
        else $error("switching style outputs inconsistent");

    // Every ack answers a request seen the cycle before
    chk_ack_on_req: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> $past(req))
        else $error("ack without a request");

endmodule // boostc_ctrl

/* File: dv/tb_boostc_ctrl.sv */
// Self-checking testbench for the boost regulator control block
`timescale 1ns/10ps

module tb_boostc_ctrl;
    localparam logic [9:0] CTRL_ADR = 10'h198;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic standby_i = 1'b0;
    logic heavy_load_i = 1'b0;
    logic [4:0] slot = 5'h00;
    logic [1:0] volt_o;
    logic en_o, pfm_o, heavy_o, in_seq_o;
    logic [1:0] start_o;
    logic [31:0] rd;
    int mismatches = 0;
    int cmp_count = 0;

    // ----------------------------------------
    // Clock and device
    // ----------------------------------------
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    boostc_ctrl boostc_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .standby_i(standby_i),
        .heavy_load_i(heavy_load_i), .boost_sequence_slot_i(slot),
        .boost_voltage_select_o(volt_o), .boost_enable_o(en_o), .boost_pfm_o(pfm_o),
        .boost_heavy_o(heavy_o), .boost_in_sequence_o(in_seq_o),
        .boost_start_mode_o(start_o)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Expected {enable, pfm, heavy} for a mode code and load level
    function automatic logic [2:0] exp_mode(input logic [1:0] m, input logic hl);
        case (m)
            2'h0: return 3'h0;
            2'h1: return 3'h6;
            2'h2: return hl ? 3'h5 : 3'h6;
            default: return 3'h5;
        endcase
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Pin group: volt, enable, pfm, heavy, in sequence, start mode
    task automatic cmp_pins(input logic [7:0] exp, input string msg);
        cmp_count++;
        if ({volt_o, en_o, pfm_o, heavy_o, in_seq_o, start_o} !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg,
                     {volt_o, en_o, pfm_o, heavy_o, in_seq_o, start_o}, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Classic single cycle; held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [9:0] adr, input logic [3:0] sel,
                           input logic [31:0] wdat, output logic [31:0] rdat);
        int n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wdat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            mismatches++;
            $display("MISMATCH %0t bus timeout", $time);
            end_of_test();
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] d);
        logic [31:0] r;
        wb_xfer(1'b1, CTRL_ADR, 4'h1, {24'h0, d}, r);
    endtask

    task automatic rd_chk(input logic [9:0] adr, input logic [7:0] exp, input string msg);
        logic [31:0] r;
        wb_xfer(1'b0, adr, 4'hF, 32'h0, r);
        cmp_word(r, {24'h0, exp}, msg);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        idle(10);
        cmp_pins(8'h00, "pins in reset");
        rst_i <= 1'b0;
        idle(10);
        rd_chk(CTRL_ADR, 8'h48, "reset value");
        cmp_pins({2'h0, exp_mode(2'h2, 1'b0), 3'h0}, "pins after reset");
        $display("test reset done");
    endtask

    task automatic t_fields();
        wr(8'hFF);
        // reserved bits and read-only run mode
        rd_chk(CTRL_ADR, 8'h6B, "all ones write");
        wr(8'h00);
        rd_chk(CTRL_ADR, 8'h08, "all zero write");
        for (int v = 0; v < 4; v++) begin
            wr(8'h40 | 8'(v));
            rd_chk(CTRL_ADR, 8'h48 | 8'(v), "volt readback");
            cmp_pins({2'(v), exp_mode(2'h2, 1'b0), 3'h0}, "volt pins");
        end
        $display("test fields done");
    endtask

    task automatic t_refuse();
        wb_xfer(1'b1, CTRL_ADR, 4'hE, 32'h0000_0001, rd);
        rd_chk(CTRL_ADR, 8'h4B, "lane zero off");
        wb_xfer(1'b1, 10'h19C, 4'hF, 32'h0000_0000, rd);
        rd_chk(10'h19C, 8'h00, "unmapped read");
        rd_chk(10'h066, 8'h00, "index as byte address");
        rd_chk(CTRL_ADR, 8'h4B, "unmapped write");
        $display("test refuse done");
    endtask

    task automatic t_standby();
        standby_i <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr({1'b0, 2'(m), 5'h00});
            idle(10);
            cmp_pins({2'h0, exp_mode(2'(m), 1'b0), 3'h0}, "standby mode");
        end
        wr(8'h00);
        standby_i <= 1'b0;
        idle(10);
        // Standby field is OFF, run field still auto
        cmp_pins({2'h0, exp_mode(2'h2, 1'b0), 3'h0}, "run mode");
        $display("test standby done");
    endtask

    task automatic t_auto();
        heavy_load_i <= 1'b1;
        idle(12);
        cmp_pins({2'h0, exp_mode(2'h2, 1'b1), 3'h0}, "auto heavy");
        heavy_load_i <= 1'b0;
        idle(12);
        cmp_pins({2'h0, exp_mode(2'h2, 1'b0), 3'h0}, "auto light");
        $display("test auto done");
    endtask

    task automatic t_seq();
        logic [4:0] vals [4] = '{5'h01, 5'h10, 5'h1F, 5'h00};
        foreach (vals[i]) begin
            slot <= vals[i];
            idle(3);
            cmp_pins({5'h06, vals[i] != 5'h00, (vals[i] != 5'h00) ? 2'h2 : 2'h0},
                     "sequence slot");
        end
        $display("test sequence done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        t_reset();
        t_fields();
        t_refuse();
        t_standby();
        t_auto();
        t_seq();
        end_of_test();
    end
endmodule // tb_boostc_ctrl
